// ===== core/pvs_regs.vh
// Constants for the performance-state voltage/frequency sequencer
`ifndef PVS_REGS_VH
`define PVS_REGS_VH
`define PVS_VID_STEP_UV      12500
`define PVS_VID_SETTLE_NS    1000
`define PVS_CLK_PERIOD_NS    8
`define PVS_VID_SETTLE_CYC   ((`PVS_VID_SETTLE_NS + `PVS_CLK_PERIOD_NS - 1) / `PVS_CLK_PERIOD_NS)
`define PVS_RATIO_RESET      8'h0C
`define PVS_VID_RESET        8'h20
`define PVS_RATIO_MAX        8'h10
`endif

// ===== core/pvs_vid_stepper.v
// Steps the voltage code one unit at a time toward a target
`include "pvs_regs.vh"
module pvs_vid_stepper #(
    parameter W      = 8,
    parameter SETTLE = `PVS_VID_SETTLE_CYC
) (
    // Clock and reset
    input  wire         mclk,
    input  wire         rstn,
    input  wire         ce,
    // Control
    input  wire         go,
    input  wire [W-1:0] target,
    // Status
    output reg  [W-1:0] vid,
    output reg          done
);
    reg [15:0] settle;
    reg        active;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            vid    <= `PVS_VID_RESET;
            settle <= 16'h0000;
            active <= 1'b0;
            done   <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (go && !active) begin
                active <= 1'b1;
                settle <= 16'h0000;
            end else if (active) begin
                if (settle != 16'h0000) begin
                    settle <= settle - 16'h0001;
                end else if (vid == target) begin
                    active <= 1'b0;
                    done   <= 1'b1;
                end else begin
                    // One 12.5 mV step per settle interval
                    if (target > vid) vid <= vid + 1'b1;
                    else vid <= vid - 1'b1;
                    settle <= SETTLE[15:0];
                end
            end
        end
    end
endmodule

// ===== core/pvs_sequencer.v
// Top of the performance-state voltage/frequency sequencer
`include "pvs_regs.vh"
module pvs_sequencer #(
    parameter RW        = 8,
    parameter VW        = 8,
    parameter RATIO_MAX = `PVS_RATIO_MAX
) (
    // Clock and reset
    input  wire          mclk,
    input  wire          rstn,
    input  wire          ce,
    // Operating-point request from the model specific register
    input  wire          req_valid,
    input  wire [RW-1:0] req_ratio,
    input  wire [VW-1:0] req_vid,
    // Core clock generator
    output reg  [RW-1:0] core_ratio,
    output reg           relock_req,
    input  wire          pll_lock,
    // Regulator
    output reg  [VW-1:0] voltage_id_code,
    // Status
    output reg           busy
);
    // State codes
    localparam S_IDLE  = 3'h0;
    localparam S_UPV   = 3'h1;
    localparam S_RELK  = 3'h2;
    localparam S_WAITL = 3'h3;
    localparam S_DNV   = 3'h4;

    // Sequence state and its next value
    reg [2:0]     state;
    reg [2:0]     next_state;
    reg           up;
    reg           next_up;
    reg [RW-1:0]  tgt_ratio;
    reg [RW-1:0]  next_tgt_ratio;
    reg [VW-1:0]  tgt_vid;
    reg [VW-1:0]  next_tgt_vid;
    reg           vgo;
    reg           next_vgo;

    // Next values of the outputs
    reg [RW-1:0]  next_core_ratio;
    reg           next_relock_req;
    reg           next_busy;

    // Lock synchroniser
    reg           lock_m;
    reg           lock_s;

    // Stepper status and request decode
    wire [VW-1:0] vid_now;
    wire          vdone;
    wire [RW-1:0] req_clamped;
    wire          req_rises;

    // Clamp to the rated maximum
    function [RW-1:0] clamp;
        input [RW-1:0] r;
        begin
            clamp = (r > RATIO_MAX[RW-1:0]) ? RATIO_MAX[RW-1:0] : r;
        end
    endfunction

    // Request above the ratio in force
    function rises;
        input [RW-1:0] want;
        input [RW-1:0] have;
        begin
            rises = (want > have);
        end
    endfunction

    assign req_clamped = clamp(req_ratio);
    assign req_rises   = rises(req_clamped, core_ratio);

    // Voltage code stepper
    pvs_vid_stepper #(
        .W      (VW),
        .SETTLE (`PVS_VID_SETTLE_CYC)
    ) u_step (
        .mclk   (mclk),
        .rstn   (rstn),
        .ce     (ce),
        .go     (vgo),
        .target (tgt_vid),
        .vid    (vid_now),
        .done   (vdone)
    );

    // Lock pin synchroniser; resets to locked so no false loss follows reset
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lock_m <= 1'b1;
            lock_s <= 1'b1;
        end else if (ce) begin
            lock_m <= pll_lock;
            lock_s <= lock_m;
        end
    end

    // Next-state and next-output decode
    always @* begin
        next_state      = state;
        next_up         = up;
        next_tgt_ratio  = tgt_ratio;
        next_tgt_vid    = tgt_vid;
        next_vgo        = 1'b0;
        next_core_ratio = core_ratio;
        next_relock_req = relock_req;
        next_busy       = busy;
        case (state)
            S_IDLE: begin
                // New target only taken while idle
                if (req_valid) begin
                    next_tgt_ratio = req_clamped;
                    next_tgt_vid   = req_vid;
                    next_busy      = 1'b1;
                    if (req_rises) begin
                        // Supply first, ratio afterwards
                        next_up    = 1'b1;
                        next_vgo   = 1'b1;
                        next_state = S_UPV;
                    end else begin
                        // Ratio first, supply afterwards
                        next_up    = 1'b0;
                        next_state = S_RELK;
                    end
                end
            end
            S_UPV: begin
                // Ratio held until the code reaches its target
                if (vdone) begin
                    next_state = S_RELK;
                end
            end
            S_RELK: begin
                // Present new ratio; ask for relock until lock drops
                next_core_ratio = tgt_ratio;
                next_relock_req = 1'b1;
                if (!lock_s) begin
                    next_relock_req = 1'b0;
                    next_state      = S_WAITL;
                end
            end
            S_WAITL: begin
                // Supply code untouched until lock returns
                if (lock_s) begin
                    if (up) begin
                        next_busy  = 1'b0;
                        next_state = S_IDLE;
                    end else begin
                        next_vgo   = 1'b1;
                        next_state = S_DNV;
                    end
                end
            end
            S_DNV: begin
                // Supply steps toward its target after the relock
                if (vdone) begin
                    next_busy  = 1'b0;
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state      = S_IDLE;
                next_relock_req = 1'b0;
                next_busy       = 1'b0;
            end
        endcase
    end

    // Sequence registers
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= S_IDLE;
            up    <= 1'b0;
            vgo   <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            up    <= next_up;
            vgo   <= next_vgo;
        end
    end

    // Target point latched at the take
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tgt_ratio <= `PVS_RATIO_RESET;
            tgt_vid   <= `PVS_VID_RESET;
        end else if (ce) begin
            tgt_ratio <= next_tgt_ratio;
            tgt_vid   <= next_tgt_vid;
        end
    end

    // Bus clock is not an output; only ratio and supply code move
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            core_ratio <= `PVS_RATIO_RESET;
            relock_req <= 1'b0;
        end else if (ce) begin
            core_ratio <= next_core_ratio;
            relock_req <= next_relock_req;
        end
    end

    // Supply code follows the stepper one cycle late
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            voltage_id_code <= `PVS_VID_RESET;
        end else if (ce) begin
            voltage_id_code <= vid_now;
        end
    end

    // Busy from take to end of sequence
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else if (ce) begin
            busy <= next_busy;
        end
    end
endmodule

// ===== sim/pvs_props.sv
// Assertions on the sequencer ports
module pvs_props #(parameter RW = 8, VW = 8, RATIO_MAX = 8'h10) (
    // Clock, reset, request, ratio and supply code
    input wire          mclk, rstn, ce, req_valid,
    input wire [RW-1:0] req_ratio, core_ratio,
    input wire [VW-1:0] req_vid, voltage_id_code,
    // Lock and status
    input wire          relock_req, pll_lock, busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [VW-1:0] tv;
    logic [RW-1:0] tr;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Target point captured when a request is taken
    always_ff @(posedge mclk) if (!busy && req_valid && ce) tv <= req_vid;
    always_ff @(posedge mclk)
        if (!busy && req_valid && ce) tr <= (req_ratio > RATIO_MAX) ? RW'(RATIO_MAX) : req_ratio;
    a_ratio_cap: assert property (core_ratio <= RATIO_MAX)
        else $error("core ratio above max");
    a_vid_one_step: assert property ($changed(voltage_id_code) |->
        (voltage_id_code - $past(voltage_id_code)) inside {VW'(1), {VW{1'b1}}})
        else $error("code moved more than one step");
    a_ratio_busy: assert property ($changed(core_ratio) |-> busy)
        else $error("ratio changed while idle");
    a_vid_busy: assert property ($changed(voltage_id_code) |-> busy || $past(busy))
        else $error("code changed while idle");
    a_ratio_relock: assert property ($changed(core_ratio) |-> relock_req)
        else $error("ratio change without relock");
    a_relock_vid_hold: assert property (relock_req && $past(relock_req) |->
        $stable(voltage_id_code)) else $error("code moved during relock");
    a_up_vid_first: assert property (core_ratio > $past(core_ratio) |->
        voltage_id_code == tv) else $error("ratio rose before supply");
    a_down_ratio_first: assert property (voltage_id_code < $past(voltage_id_code) |->
        core_ratio == tr && !relock_req) else $error("supply fell before relock");
    a_busy_take: assert property (!busy && req_valid && ce |=> busy)
        else $error("request not taken");
    c_relock: cover property ($rose(relock_req));
    c_refused: cover property (busy && req_valid);
    c_done: cover property ($fell(busy));
endmodule
bind pvs_sequencer pvs_props #(.RW(RW), .VW(VW), .RATIO_MAX(RATIO_MAX)) u_props (
    .mclk(mclk), .rstn(rstn), .ce(ce), .req_valid(req_valid), .req_ratio(req_ratio),
    .core_ratio(core_ratio), .req_vid(req_vid), .voltage_id_code(voltage_id_code),
    .relock_req(relock_req), .pll_lock(pll_lock), .busy(busy));

// ===== sim/pvs_pll_model.sv
// Core clock generator model: drops lock on relock, regains it later
module pvs_pll_model #(parameter int LOCK_CYC = 20) (
    input wire   mclk,
    input wire   rstn,
    input wire   relock_req,
    output logic pll_lock
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pll_lock <= 1'b1;
            cnt <= 0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            pll_lock <= (cnt == 1);
        end else if (relock_req && pll_lock) begin
            cnt <= LOCK_CYC;
            pll_lock <= 1'b0;
        end
    end
endmodule

// ===== sim/pvs_sequencer_bench.sv
// Testbench for the voltage/frequency sequencer
`include "pvs_regs.vh"
module pvs_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk = 1'b0, rstn = 1'b0, ce = 1'b1, req_valid = 1'b0;
    logic [7:0] req_ratio = 8'h00, req_vid = 8'h00, core_ratio, vid;
    logic       relock_req, pll_lock, busy;
    int         fails = 0, n_checks = 0;
    always #4 mclk = ~mclk;
    pvs_sequencer DUT (.mclk(mclk), .rstn(rstn), .ce(ce), .req_valid(req_valid),
        .req_ratio(req_ratio), .req_vid(req_vid), .core_ratio(core_ratio),
        .relock_req(relock_req), .pll_lock(pll_lock), .voltage_id_code(vid), .busy(busy));
    pvs_pll_model pll (.mclk(mclk), .rstn(rstn), .relock_req(relock_req), .pll_lock(pll_lock));
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request, a refused one while busy, then wait for completion
    task automatic op(logic [7:0] r, logic [7:0] v, logic [7:0] er, logic [7:0] ev);
        @(negedge mclk);
        req_valid = 1'b1;
        req_ratio = r;
        req_vid = v;
        @(negedge mclk);
        chk("busy", 8'h01, {7'h00, busy});
        req_ratio = 8'h0D;
        req_vid = 8'h1F;
        @(negedge mclk);
        req_valid = 1'b0;
        wait_idle();
        chk("ratio", er, core_ratio);
        chk("vid", ev, vid);
    endtask
    task automatic t_reset();
        chk("ratio", `PVS_RATIO_RESET, core_ratio);
        chk("vid", `PVS_VID_RESET, vid);
        chk("busy", 8'h00, {7'h00, busy});
    endtask
    task automatic t_up();
        op(8'h0E, 8'h22, 8'h0E, 8'h22);
    endtask
    task automatic t_clamp();
        op(8'hFF, 8'h23, `PVS_RATIO_MAX, 8'h23);
    endtask
    task automatic t_down();
        op(8'h0C, 8'h21, 8'h0C, 8'h21);
    endtask
    // Wait for the sequence to end; a hang counts as a mismatch
    task automatic wait_idle();
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge mclk);
        chk("busy end", 8'h00, {7'h00, busy});
        @(negedge mclk);
    endtask
    // Clock enable low freezes a taken request before its first step
    task automatic t_freeze();
        @(negedge mclk);
        req_valid = 1'b1;
        req_ratio = 8'h0D;
        req_vid = 8'h22;
        @(negedge mclk);
        req_valid = 1'b0;
        ce = 1'b0;
        repeat (300) @(negedge mclk);
        chk("frozen vid", 8'h21, vid);
        chk("frozen busy", 8'h01, {7'h00, busy});
        ce = 1'b1;
        wait_idle();
        chk("ratio", 8'h0D, core_ratio);
        chk("vid", 8'h22, vid);
    endtask
    // Reset in the middle of an upward sequence, then a fresh request
    task automatic t_midreset();
        @(negedge mclk);
        req_valid = 1'b1;
        req_ratio = 8'h10;
        req_vid = 8'h24;
        @(negedge mclk);
        req_valid = 1'b0;
        repeat (60) @(negedge mclk);
        chk("vid mid", 8'h23, vid);
        chk("ratio mid", 8'h0D, core_ratio);
        rstn = 1'b0;
        @(negedge mclk);
        t_reset();
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        t_reset();
        t_up();
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        complete_run();
    end
    initial begin
        repeat (4) @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_up();
        t_clamp();
        t_down();
        t_freeze();
        t_midreset();
        complete_run();
    end
endmodule
